// ### rtl/xim_exec.sv
// Execution unit for indexed moves, literal push and call through W.
// Assumes the core presents each instruction word during Q1 and that
// data memory answers a read within the same phase.
// What this block does
// - Call via W pushes PC+2, then loads PC from W and latches, 2 cycles.
// - Absolute move word one is 1110 1011 0 plus a 7-bit stack offset.
// - Absolute move destination is the 12-bit literal of 1111 word two.
// - Absolute move source and destination span all 4096 bytes.
// - A source on an indirect register reads as 00h for either move.
// - Indexed move words are 1 and source offset, then 1111 and dest offset.
// - Indexed move with an indirect destination still reads its source but writes nothing.
// - Push literal 1111 1010 k writes k at the stack pointer address.
// - Push literal then decrements the stack pointer by one, one cycle.
module xim_exec (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Instruction stream
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  // Core state
  input wire logic [7:0] working_register,
  input wire logic [xim_pkg::PC_W-1:0] pc_current,
  input wire logic [7:0] pc_latch_high,
  input wire logic [4:0] pc_latch_upper,
  input wire logic ssp_load,
  input wire logic [xim_pkg::ADDR_W-1:0] ssp_load_value,
  // Data memory
  input wire logic [7:0] mem_rdata,
  output xim_pkg::xim_mem_req_t mem_req,
  // Program counter and return stack
  output xim_pkg::xim_pc_req_t pc_req,
  // Status
  output logic [3:0] phase,
  output logic busy,
  output logic [xim_pkg::ADDR_W-1:0] software_stack_pointer
);

  xim_pkg::xim_phase_t phase_q, phase_d;
  xim_pkg::xim_state_t state_q, state_d;
  xim_pkg::xim_mem_req_t mem_q, mem_d;
  xim_pkg::xim_pc_req_t pc_q, pc_d;
  logic [xim_pkg::ADDR_W-1:0] ssp_q, ssp_d;
  logic [xim_pkg::ADDR_W-1:0] src_q, src_d;
  logic [xim_pkg::ADDR_W-1:0] dst_q, dst_d;
  logic [7:0] data_q, data_d;
  logic [7:0] lit_q, lit_d;
  logic src_ind_q, src_ind_d;
  logic dst_ind_q, dst_ind_d;
  logic push_q, push_d;
  logic call_q, call_d;
  logic busy_q;

  // Phase strobes
  wire logic at_q1 = (phase_q == xim_pkg::PH_Q1);
  wire logic at_q2 = (phase_q == xim_pkg::PH_Q2);
  wire logic at_q3 = (phase_q == xim_pkg::PH_Q3);
  wire logic at_q4 = (phase_q == xim_pkg::PH_Q4);
  wire logic take = at_q1 && instr_valid;

  // Decode of the word on the bus
  // indexed-to-absolute prefix
  wire logic [7:0] opc = instr_word[xim_pkg::WORD_W-1:xim_pkg::OPC_LSB];
  wire logic is_idx = (opc == xim_pkg::OP_IDX_MOVE);
  wire logic is_abs1 = is_idx && !instr_word[xim_pkg::SEL_BIT];
  wire logic is_rel1 = is_idx && instr_word[xim_pkg::SEL_BIT];
  wire logic is_push = (opc == xim_pkg::OP_PUSH_LIT);
  wire logic is_call = (instr_word == xim_pkg::OP_CALL_W);
  wire logic is_second =
    (instr_word[xim_pkg::WORD_W-1:xim_pkg::SEC_LSB] == xim_pkg::OP_SECOND);

  // Address arithmetic, wraps inside the 4096-byte space
  // full 12-bit address space
  wire logic [xim_pkg::ADDR_W-1:0] offset = {
    {(xim_pkg::ADDR_W - xim_pkg::OFF_W){1'b0}},
    instr_word[xim_pkg::OFF_W-1:0]
  };
  wire logic [xim_pkg::ADDR_W-1:0] off_addr = ssp_q + offset;
  wire logic off_ind =
    (off_addr >= xim_pkg::IND_LO) && (off_addr <= xim_pkg::IND_HI);
  wire logic [xim_pkg::ADDR_W-1:0] abs_addr =
    instr_word[xim_pkg::ADDR_W-1:0];
  wire logic [xim_pkg::PC_W-1:0] ret_addr =
    pc_current + xim_pkg::RET_STEP;
  wire logic [xim_pkg::PC_W-1:0] call_target =
    {pc_latch_upper, pc_latch_high, working_register};

  // Phase ring
  always_comb begin
    case (phase_q)
      xim_pkg::PH_Q1: phase_d = xim_pkg::PH_Q2;
      xim_pkg::PH_Q2: phase_d = xim_pkg::PH_Q3;
      xim_pkg::PH_Q3: phase_d = xim_pkg::PH_Q4;
      xim_pkg::PH_Q4: phase_d = xim_pkg::PH_Q1;
      default: phase_d = xim_pkg::PH_Q1;
    endcase
  end

  // Sequencing and captured operands
  always_comb begin
    state_d = state_q;
    src_d = src_q;
    dst_d = dst_q;
    lit_d = lit_q;
    src_ind_d = src_ind_q;
    dst_ind_d = dst_ind_q;
    push_d = push_q;
    call_d = call_q;
    data_d = data_q;
    if (at_q1) begin
      push_d = 1'b0;
      call_d = 1'b0;
      case (state_q)
        xim_pkg::ST_FIRST: begin
          if (take && (is_abs1 || is_rel1)) begin
            // source from stack pointer plus offset
            src_d = off_addr;
            src_ind_d = off_ind;
            state_d = is_abs1 ? xim_pkg::ST_ABS2 : xim_pkg::ST_IDX2;
          end else if (take && is_push) begin
            lit_d = instr_word[xim_pkg::OPC_LSB-1:0];
            push_d = 1'b1;
          end else if (take && is_call) begin
            call_d = 1'b1;
            state_d = xim_pkg::ST_CALL2;
          end
        end
        xim_pkg::ST_ABS2: begin
          dst_d = abs_addr;
          dst_ind_d = !(take && is_second);
          state_d = xim_pkg::ST_FIRST;
        end
        xim_pkg::ST_IDX2: begin
          // destination from stack pointer plus offset
          dst_d = off_addr;
          dst_ind_d = off_ind || !(take && is_second);
          state_d = xim_pkg::ST_FIRST;
        end
        xim_pkg::ST_CALL2: state_d = xim_pkg::ST_FIRST;
        default: state_d = xim_pkg::ST_FIRST;
      endcase
    end
    if (at_q4 && (state_q != xim_pkg::ST_FIRST) && mem_q.rd) begin
      data_d = mem_rdata;
    end else if (at_q4 && src_ind_q) begin
      data_d = xim_pkg::FORCED_DATA;
    end
  end

  // Bus requests, set one edge early so they stand during their phase
  always_comb begin
    mem_d = '0;
    pc_d = '0;
    ssp_d = ssp_q;
    if (at_q3 && !src_ind_q &&
        (state_q == xim_pkg::ST_ABS2 || state_q == xim_pkg::ST_IDX2)) begin
      // source read in Q4 of cycle one
      mem_d.rd = 1'b1;
      mem_d.addr = src_q;
    end
    if (at_q3 && state_q == xim_pkg::ST_FIRST && !dst_ind_q) begin
      // destination write in Q4 of cycle two
      mem_d.wr = 1'b1;
      mem_d.addr = dst_q;
      mem_d.wdata = data_q;
    end
    if (at_q3 && push_q) begin
      mem_d.wr = 1'b1;
      mem_d.addr = ssp_q;
      mem_d.wdata = lit_q;
    end
    if (at_q2 && call_q) begin
      // return address onto the return stack in Q3
      pc_d.push = 1'b1;
      pc_d.push_value = ret_addr;
    end
    if (at_q3 && call_q) begin
      // new program counter from W and latches
      pc_d.load = 1'b1;
      pc_d.load_value = call_target;
    end
    if (at_q4 && push_q) begin
      ssp_d = ssp_q - xim_pkg::SSP_STEP;
    end else if (ssp_load) begin
      ssp_d = ssp_load_value;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      phase_q <= xim_pkg::PH_Q1;
      state_q <= xim_pkg::ST_FIRST;
      mem_q <= '0;
      pc_q <= '0;
      ssp_q <= xim_pkg::SSP_RESET;
      src_q <= '0;
      dst_q <= '0;
      data_q <= '0;
      lit_q <= '0;
      src_ind_q <= 1'b0;
      dst_ind_q <= 1'b1;
      push_q <= 1'b0;
      call_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      state_q <= state_d;
      mem_q <= mem_d;
      pc_q <= pc_d;
      ssp_q <= ssp_d;
      src_q <= src_d;
      dst_q <= dst_d;
      data_q <= data_d;
      lit_q <= lit_d;
      src_ind_q <= src_ind_d;
      dst_ind_q <= (at_q4 && state_q == xim_pkg::ST_FIRST) ? 1'b1 : dst_ind_d;
      push_q <= push_d;
      call_q <= call_d;
      busy_q <= (state_d != xim_pkg::ST_FIRST);
    end
  end

  // Registered outputs
  assign mem_req = mem_q;
  assign pc_req = pc_q;
  assign phase = phase_q;
  assign busy = busy_q;
  assign software_stack_pointer = ssp_q;

endmodule

// ### rtl/xim_pkg.sv
// Constants and carriers for the extended indexed move / push unit.
// Assumes one clock with four phases per instruction cycle.
package xim_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned PC_W = 21;

  // Opcode fields
  localparam logic [7:0] OP_IDX_MOVE = 8'heb;
  localparam logic [7:0] OP_PUSH_LIT = 8'hfa;
  localparam logic [3:0] OP_SECOND = 4'hf;
  localparam logic [15:0] OP_CALL_W = 16'h0014;
  localparam int unsigned SEL_BIT = 7;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned OPC_LSB = 8;
  localparam int unsigned SEC_LSB = 12;
  localparam int unsigned OFF_W = 7;

  // Indirect addressing register window
  localparam logic [ADDR_W-1:0] IND_LO = 12'hfe0;
  localparam logic [ADDR_W-1:0] IND_HI = 12'hfef;

  localparam logic [ADDR_W-1:0] SSP_RESET = 12'h000;
  localparam logic [7:0] FORCED_DATA = 8'h00;
  localparam logic [PC_W-1:0] RET_STEP = 21'h000002;
  localparam logic [ADDR_W-1:0] SSP_STEP = 12'h001;

  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } xim_phase_t;

  typedef enum logic [3:0] {
    ST_FIRST = 4'b0001,
    ST_ABS2 = 4'b0010,
    ST_IDX2 = 4'b0100,
    ST_CALL2 = 4'b1000
  } xim_state_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } xim_mem_req_t;

  typedef struct packed {
    logic push;
    logic [PC_W-1:0] push_value;
    logic load;
    logic [PC_W-1:0] load_value;
  } xim_pc_req_t;

endpackage

// ### bench/xim_exec_props.sv
// Checker for the indexed move and literal push unit.
// Sees only the ports of xim_exec; attached by bind.
module xim_exec_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Instruction and core state
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [7:0] working_register,
  input wire logic [xim_pkg::PC_W-1:0] pc_current,
  input wire logic [7:0] pc_latch_high,
  input wire logic [4:0] pc_latch_upper,
  input wire logic ssp_load,
  // Outputs
  input wire xim_pkg::xim_mem_req_t mem_req,
  input wire xim_pkg::xim_pc_req_t pc_req,
  input wire logic [3:0] phase,
  input wire logic busy,
  input wire logic [xim_pkg::ADDR_W-1:0] software_stack_pointer
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  wire take = phase == 4'b0001 && instr_valid && !busy;
  wire t_mv = take && instr_word[15:8] == xim_pkg::OP_IDX_MOVE;
  wire t_pl = take && instr_word[15:8] == xim_pkg::OP_PUSH_LIT;
  wire t_cw = take && instr_word == xim_pkg::OP_CALL_W;
  wire [11:0] src = software_stack_pointer + {5'h00, instr_word[6:0]};
  wire src_ind = src >= xim_pkg::IND_LO && src <= xim_pkg::IND_HI;
  sequence s_quad;
    phase == 4'b0010 ##1 phase == 4'b0100 ##1 phase == 4'b1000
      ##1 phase == 4'b0001;
  endsequence
  sequence s_pw;
    mem_req.wr && mem_req.addr == $past(software_stack_pointer, 3)
      && mem_req.wdata == $past(instr_word[7:0], 3);
  endsequence
  property p_phase;
    phase == 4'b0001 |=> s_quad;
  endproperty
  a_phase: assert property (p_phase) else $error("phase order wrong");
  property p_rd_q4;
    mem_req.rd |-> phase == 4'b1000 && !mem_req.wr;
  endproperty
  a_rd_q4: assert property (p_rd_q4) else $error("read off Q4");
  property p_wr_q4;
    mem_req.wr |-> phase == 4'b1000;
  endproperty
  a_wr_q4: assert property (p_wr_q4) else $error("write off Q4");
  property p_src;
    t_mv |-> ##3 (mem_req.rd == !$past(src_ind, 3))
      && (!mem_req.rd || mem_req.addr == $past(src, 3));
  endproperty
  a_src: assert property (p_src) else $error("source read wrong");
  property p_busy;
    t_mv |-> ##1 busy [*4] ##1 !busy;
  endproperty
  a_busy: assert property (p_busy) else $error("move length wrong");
  property p_push;
    t_pl |-> ##3 s_pw ##1 software_stack_pointer
      == $past(software_stack_pointer) - xim_pkg::SSP_STEP;
  endproperty
  a_push: assert property (p_push) else $error("push wrong");
  property p_call;
    t_cw |-> ##2 pc_req.push
      && pc_req.push_value == $past(pc_current) + xim_pkg::RET_STEP
      ##1 pc_req.load && pc_req.load_value == {$past(pc_latch_upper),
      $past(pc_latch_high), $past(working_register)};
  endproperty
  a_call: assert property (p_call) else $error("call wrong");
  property p_ssp;
    !$stable(software_stack_pointer) |-> $past(ssp_load)
      || ($past(mem_req.wr) && software_stack_pointer
      == $past(software_stack_pointer) - xim_pkg::SSP_STEP);
  endproperty
  a_ssp: assert property (p_ssp) else $error("pointer moved");
endmodule

bind xim_exec xim_exec_chk u_chk (.clk_sys, .srst, .instr_valid,
  .instr_word, .working_register, .pc_current, .pc_latch_high,
  .pc_latch_upper, .ssp_load, .mem_req, .pc_req, .phase, .busy,
  .software_stack_pointer);

// ### bench/xim_mem_model.sv
// Data memory model on the far side of the unit.
// Answers reads in the same phase; released bus shows inverted data.
module xim_mem_model (
  // Clock
  input wire logic clk_sys,
  // Bus
  input wire xim_pkg::xim_mem_req_t mem_req,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [4096];
  logic [7:0] last_q = 8'h5a;
  assign mem_rdata = mem_req.rd ? mem[mem_req.addr] : ~last_q;
  always @(posedge clk_sys) begin
    if (mem_req.rd) last_q <= mem[mem_req.addr];
    if (mem_req.wr) mem[mem_req.addr] <= mem_req.wdata;
  end
endmodule

// ### bench/testbench.sv
// Self-checking bench for the indexed move and push unit.
// Memory model on the bus; call values fixed from time zero.
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
  failures++; $display("unexpected %s exp %h got %h", n, e, s); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, srst, instr_valid, ssp_load, busy;
  logic [15:0] instr_word;
  logic [7:0] working_register, pc_latch_high, mem_rdata;
  logic [4:0] pc_latch_upper;
  logic [20:0] pc_current, push_v, load_v;
  logic [11:0] ssp_load_value, software_stack_pointer;
  logic [3:0] phase;
  xim_pkg::xim_mem_req_t mem_req;
  xim_pkg::xim_pc_req_t pc_req;
  int failures = 0, check_count = 0, cycles = 0;
  xim_exec DUT (.clk_sys, .srst, .instr_valid, .instr_word,
    .working_register, .pc_current, .pc_latch_high, .pc_latch_upper,
    .ssp_load, .ssp_load_value, .mem_rdata, .mem_req, .pc_req, .phase,
    .busy, .software_stack_pointer);
  xim_mem_model MEM (.clk_sys, .mem_req, .mem_rdata);
  initial begin
    clk_sys = 0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (pc_req.push) push_v <= pc_req.push_value;
    if (pc_req.load) load_v <= pc_req.load_value;
    if (cycles == 2000) begin
      failures++;
      tally_and_finish();
    end
  end
  task tally_and_finish;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task cyc(input logic [15:0] w);
    instr_word <= w;
    instr_valid <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask
  task pause;
    instr_valid <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  task sp(input logic [11:0] v);
    instr_valid <= 1'b0;
    ssp_load <= 1'b1;
    ssp_load_value <= v;
    @(posedge clk_sys);
    ssp_load <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  task t_push;
    sp(12'h1ec);
    cyc(16'hfa08);
    pause();
    `CHK("push mem", 8'h08, MEM.mem[12'h1ec])
    `CHK("push sp", 12'h1eb, software_stack_pointer)
    sp(12'h000);
    cyc(16'hfaff);
    cyc(16'hfa3c);
    pause();
    `CHK("wrap mem", 8'h3c, MEM.mem[12'hfff])
    `CHK("wrap sp", 12'hffe, software_stack_pointer)
    $display("push test done");
  endtask
  task t_abs;
    MEM.mem[12'h085] = 8'h33;
    MEM.mem[12'hfe0] = 8'h5a;
    sp(12'h080);
    cyc(16'heb05);
    cyc(16'hf123);
    pause();
    `CHK("abs dst", 8'h33, MEM.mem[12'h123])
    sp(12'hfd0);
    cyc(16'heb10);
    cyc(16'hffe5);
    pause();
    `CHK("abs ind", 8'h00, MEM.mem[12'hfe5])
    sp(12'hf80);
    cyc(16'heb7f);
    cyc(16'hf000);
    pause();
    `CHK("abs edge", 8'h3c, MEM.mem[12'h000])
    $display("absolute move test done");
  endtask
  task t_idx;
    MEM.mem[12'hfef] = 8'h77;
    MEM.mem[12'hfd1] = 8'h44;
    MEM.mem[12'h086] = 8'h11;
    sp(12'h080);
    cyc(16'heb85);
    cyc(16'he006);
    pause();
    `CHK("bad word", 8'h11, MEM.mem[12'h086])
    cyc(16'heb85);
    cyc(16'hfab6);
    pause();
    `CHK("idx dst", 8'h33, MEM.mem[12'h0b6])
    sp(12'hfd0);
    cyc(16'heb81);
    cyc(16'hf01f);
    pause();
    `CHK("idx ind", 8'h77, MEM.mem[12'hfef])
    $display("indexed move test done");
  endtask
  task t_call;
    cyc(xim_pkg::OP_CALL_W);
    cyc(16'h0000);
    pause();
    `CHK("ret addr", 21'h000102, push_v)
    `CHK("new pc", 21'h001006, load_v)
    $display("call test done");
  endtask
  initial begin
    srst = 1'b1;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    ssp_load = 1'b0;
    ssp_load_value = 12'h000;
    working_register = 8'h06;
    pc_latch_high = 8'h10;
    pc_latch_upper = 5'h00;
    pc_current = 21'h000100;
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    t_push();
    t_abs();
    t_idx();
    t_call();
    tally_and_finish();
  end
endmodule
